// ==== hw/rtci_slave.sv ====
// Two-wire serial target giving byte access to the register file
`default_nettype none
`include "rtci_defines.svh"
module rtci_slave #(
   parameter logic [6:0] DEV_ADDR    = `RTCI_DEV_ADDR,     // [RL19]
   parameter int         TIMEOUT_CYC = `RTCI_TIMEOUT_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   output logic [7:0]       reg_addr_o,
   output logic [7:0]       reg_wdata_o,
   output logic             reg_we_o,
   output logic             reg_re_o,
   input  wire logic [7:0]  reg_rdata_i,
   output logic             busy_o
);
   import rtci_pkg::*;

   // ------------------------------------------------------------------
   // Pin sampling and bus conditions
   // ------------------------------------------------------------------
   logic [1:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        scl_p_q;
   logic        sda_p_q;
   logic        scl_rise_w;
   logic        scl_fall_w;
   logic        start_w;
   logic        stop_w;
   logic        tmo_w;
   logic        abort_w;

   rtci_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .async_i ({scl_i, sda_i}),
      .sync_o  (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_p_q <= `RTCI_LINE_IDLE;
         sda_p_q <= `RTCI_LINE_IDLE;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_rise_w = scl_s && !scl_p_q;
   assign scl_fall_w = !scl_s && scl_p_q;
   assign start_w    = scl_s && scl_p_q && !sda_s && sda_p_q; // [RL2]
   assign stop_w     = scl_s && scl_p_q && sda_s && !sda_p_q; // [RL3]
   assign abort_w    = start_w || stop_w || tmo_w;

   // ------------------------------------------------------------------
   // Transaction watchdog
   // ------------------------------------------------------------------
   logic busy_q;

   rtci_timeout #(
      .CYCLES (TIMEOUT_CYC)
   ) u_tmo (
      .clk_i    (clk_i),
      .rst_b_i  (rst_b_i),
      .run_i    (busy_q),
      .expire_o (tmo_w)
   );

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_q <= 1'b0;
      end else if (stop_w || tmo_w) begin
         busy_q <= 1'b0;  // [RL3] [RL7]
      end else if (start_w) begin
         busy_q <= 1'b1;  // [RL4]
      end
   end

   // ------------------------------------------------------------------
   // Byte engine
   // ------------------------------------------------------------------
   rtci_state_t state_q;
   rtci_kind_t  kind_q;
   logic [3:0]  cnt_q;
   logic [7:0]  shift_q;
   logic        oe_q;
   logic        rw_q;
   logic        nack_q;
   logic [7:0]  ptr_q;
   logic        byte_done_w;
   logic        addr_hit_w;
   logic        load_w;

   assign byte_done_w = (state_q == ST_RECV) && scl_fall_w && !abort_w
                        && (cnt_q == `RTCI_BYTE_BITS);
   assign addr_hit_w  = (shift_q[7:1] == DEV_ADDR); // [RL8]
   assign load_w      = scl_fall_w && !abort_w
                        && (((state_q == ST_ACK) && (kind_q == KD_ADDR) && rw_q)
                            || ((state_q == ST_MACK) && !nack_q)); // [RL16] [RL17]

   function automatic logic [7:0] next_ptr(input logic [7:0] p);
      next_ptr = {p[7:4], p[3:0] + 4'h1};
   endfunction

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         kind_q  <= KD_ADDR;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         oe_q    <= 1'b0;
         rw_q    <= 1'b0;
         nack_q  <= 1'b1;
      end else if (stop_w || tmo_w) begin
         state_q <= ST_IDLE;  // [RL3] [RL7]
         oe_q    <= 1'b0;
      end else if (start_w) begin
         state_q <= ST_RECV;  // [RL2] [RL4] [RL9]
         kind_q  <= KD_ADDR;
         cnt_q   <= 4'h0;
         oe_q    <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               oe_q <= 1'b0;  // [RL1]
            end
            ST_RECV: begin
               if (scl_rise_w && cnt_q != `RTCI_BYTE_BITS) begin
                  shift_q <= {shift_q[6:0], sda_s};  // [RL5]
                  cnt_q   <= cnt_q + 4'h1;
               end else if (byte_done_w) begin
                  if (kind_q == KD_ADDR && !addr_hit_w) begin
                     state_q <= ST_IDLE;  // [RL8]
                  end else begin
                     state_q <= ST_ACK;
                     oe_q    <= 1'b1;     // [RL13]
                     if (kind_q == KD_ADDR) begin
                        rw_q <= shift_q[0];  // [RL9]
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall_w) begin
                  cnt_q <= 4'h0;
                  if (load_w) begin
                     state_q <= ST_SEND;  // [RL16]
                     shift_q <= reg_rdata_i;
                     oe_q    <= !reg_rdata_i[7];
                  end else begin
                     state_q <= ST_RECV;
                     oe_q    <= 1'b0;
                     kind_q  <= (kind_q == KD_ADDR) ? KD_PTR : KD_DATA;  // [RL14]
                  end
               end
            end
            ST_SEND: begin
               if (scl_fall_w) begin
                  if (cnt_q == `RTCI_LAST_BIT) begin
                     state_q <= ST_MACK;
                     oe_q    <= 1'b0;
                  end else begin
                     cnt_q   <= cnt_q + 4'h1;
                     shift_q <= {shift_q[6:0], 1'b0};
                     oe_q    <= !shift_q[6];  // [RL10]
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise_w) begin
                  nack_q <= sda_s;  // [RL17]
               end else if (scl_fall_w) begin
                  cnt_q <= 4'h0;
                  if (load_w) begin
                     state_q <= ST_SEND;
                     shift_q <= reg_rdata_i;
                     oe_q    <= !reg_rdata_i[7];
                  end else begin
                     state_q <= ST_IDLE;  // [RL17]
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               oe_q    <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Register pointer and register file strobes
   // ------------------------------------------------------------------
   logic [7:0] wdata_q;
   logic       we_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ptr_q <= 8'h00;
      end else if (byte_done_w && kind_q == KD_PTR) begin
         ptr_q <= shift_q;            // [RL14]
      end else if ((byte_done_w && kind_q == KD_DATA) || load_w) begin
         ptr_q <= next_ptr(ptr_q);    // [RL11] [RL12] [RL18]
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wdata_q <= 8'h00;
         we_q    <= 1'b0;
      end else begin
         we_q <= byte_done_w && (kind_q == KD_DATA);  // [RL14]
         if (byte_done_w) begin
            wdata_q <= shift_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   logic [7:0] addr_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_q <= 8'h00;
      end else if (byte_done_w || load_w) begin
         addr_q <= ptr_q;
      end
   end

   assign reg_addr_o  = load_w ? ptr_q : addr_q;
   assign reg_wdata_o = wdata_q;
   assign reg_we_o    = we_q;
   assign reg_re_o    = load_w;
   assign sda_o       = 1'b0;  // [RL10]
   assign sda_oe_o    = oe_q;
   assign scl_o       = 1'b0;  // [RL10]
   assign scl_oe_o    = 1'b0;
   assign busy_o      = busy_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   idle_release_a: assert property (  // [RL1]
      @(posedge clk_i) disable iff (!rst_b_i)
      (state_q == ST_IDLE) && $past(state_q == ST_IDLE) |-> !sda_oe_o && !scl_oe_o)
      else $error("Line driven while idle");

   start_detect_a: assert property (  // [RL2]
      @(posedge clk_i) disable iff (!rst_b_i)
      start_w && !stop_w && !tmo_w |=> state_q == ST_RECV && kind_q == KD_ADDR
                                      && cnt_q == 4'h0 && !sda_oe_o)
      else $error("Start not taken into address phase");

   stop_release_a: assert property (  // [RL3]
      @(posedge clk_i) disable iff (!rst_b_i)
      stop_w |=> state_q == ST_IDLE && !sda_oe_o && !busy_o)
      else $error("Stop did not release the bus");

   restart_keep_a: assert property (  // [RL4]
      @(posedge clk_i) disable iff (!rst_b_i)
      start_w && busy_q && !tmo_w |=> busy_o && kind_q == KD_ADDR)
      else $error("Repeated start ended the transaction");

   bit_count_a: assert property (  // [RL5]
      @(posedge clk_i) disable iff (!rst_b_i)
      state_q == ST_RECV && scl_rise_w && !abort_w && cnt_q < 4'h8
      |=> cnt_q == $past(cnt_q) + 4'h1 && shift_q[0] == $past(sda_s))
      else $error("Bit not shifted in");

   timeout_idle_a: assert property (  // [RL7]
      @(posedge clk_i) disable iff (!rst_b_i)
      tmo_w |=> state_q == ST_IDLE && !busy_o && !sda_oe_o)
      else $error("Timeout did not reset the interface");

   addr_match_a: assert property (  // [RL8]
      @(posedge clk_i) disable iff (!rst_b_i)
      byte_done_w && kind_q == KD_ADDR && !addr_hit_w |=> state_q == ST_IDLE && !sda_oe_o)
      else $error("Foreign address not ignored");

   addr_ack_a: assert property (  // [RL8]
      @(posedge clk_i) disable iff (!rst_b_i)
      state_q == ST_ACK && kind_q == KD_ADDR |-> shift_q[7:1] == DEV_ADDR
                                                 && rw_q == shift_q[0])
      else $error("Acknowledged a foreign address");

   write_ack_a: assert property (  // [RL13]
      @(posedge clk_i) disable iff (!rst_b_i)
      byte_done_w && kind_q != KD_ADDR |=> sda_oe_o ##1 sda_oe_o [*1])
      else $error("Received byte not acknowledged");

   ptr_load_a: assert property (  // [RL14]
      @(posedge clk_i) disable iff (!rst_b_i)
      byte_done_w && kind_q == KD_PTR |=> ptr_q == $past(shift_q))
      else $error("Pointer not loaded");

   ptr_wrap_a: assert property (  // [RL12]
      @(posedge clk_i) disable iff (!rst_b_i)
      load_w |=> ptr_q[7:4] == $past(ptr_q[7:4])
                 && ptr_q[3:0] == $past(ptr_q[3:0]) + 4'h1 && reg_we_o == 1'b0)
      else $error("Pointer did not advance within its page");

   read_first_a: assert property (  // [RL16]
      @(posedge clk_i) disable iff (!rst_b_i)
      load_w |=> state_q == ST_SEND && shift_q == $past(reg_rdata_i)
                 && sda_oe_o == !$past(reg_rdata_i[7]))
      else $error("Read byte not presented from the pointer");

   nack_end_a: assert property (  // [RL17]
      @(posedge clk_i) disable iff (!rst_b_i)
      state_q == ST_MACK && scl_fall_w && nack_q && !abort_w
      |=> state_q == ST_IDLE && !sda_oe_o)
      else $error("Not-acknowledge did not end the read");

   ptr_keep_a: assert property (  // [RL18]
      @(posedge clk_i) disable iff (!rst_b_i)
      start_w |=> ptr_q == $past(ptr_q))
      else $error("Pointer lost across start");
endmodule
`default_nettype wire

// ==== hw/rtci_defines.svh ====
// Constants of the two-wire register access target
// What this block does
// [RL1] Both lines stay released, resting high, while no transfer runs.
// [RL2] SDA falling while SCL high is START; it opens every access.
// [RL3] SDA rising while SCL high is STOP; it ends the transfer, releases bus.
// [RL4] A START before any STOP is a repeated start: new address phase, same transaction.
// [RL5] After START data moves in 8-bit bytes, any number until STOP.
// [RL6] The master finishes each access, START to STOP, within 0.95 seconds.
// [RL7] A transaction open 0.95 seconds or more resets the interface to idle.
// [RL8] Take part only when the sent target address equals our own address.
// [RL9] First byte after any START holds target address and direction bit.
// [RL10] Lines are only pulled low or released; pull-ups make them high.
// [RL11] Each transferred data byte, written or read, advances the register pointer.
// [RL12] The pointer wraps inside 16-byte pages, e.g. 1Fh back to 10h.
// [RL13] Acknowledge matching address, register address and each written data byte.
// [RL14] Byte after write address loads the pointer; later bytes store there onward.
// [RL15] Addressed read: pointer in write direction, repeated start, address with read.
// [RL16] After acknowledging a read address, transmit data from the current pointer.
// [RL17] Master acks bytes it wants continued, ends read with not-ack and STOP.
// [RL18] A read without loading an address starts one past the last accessed.
// [RL19] The 7-bit target address is a fixed design parameter.
`ifndef RTCI_DEFINES_SVH
`define RTCI_DEFINES_SVH

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define RTCI_CLK_KHZ     100000
`define RTCI_TIMEOUT_MS  950
`define RTCI_TIMEOUT_CYC (`RTCI_TIMEOUT_MS * `RTCI_CLK_KHZ)

// ------------------------------------------------------------------
// Framing and addressing
// ------------------------------------------------------------------
`define RTCI_BYTE_BITS   4'h8
`define RTCI_LAST_BIT    4'h7
`define RTCI_DEV_ADDR    7'h32
`define RTCI_LINE_IDLE   1'b1

`endif

// ==== hw/rtci_pkg.sv ====
// Types of the two-wire register access target
`default_nettype none
package rtci_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RECV = 5'h02,
      ST_ACK  = 5'h04,
      ST_SEND = 5'h08,
      ST_MACK = 5'h10
   } rtci_state_t;

   typedef enum logic [2:0] {
      KD_ADDR = 3'h1,
      KD_PTR  = 3'h2,
      KD_DATA = 3'h4
   } rtci_kind_t;
endpackage
`default_nettype wire

// ==== hw/rtci_sync.sv ====
// Two-flop synchroniser for the bus pins
`default_nettype none
`include "rtci_defines.svh"
module rtci_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic sync_q;

      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            meta_q <= `RTCI_LINE_IDLE;
            sync_q <= `RTCI_LINE_IDLE;
         end else begin
            meta_q <= async_i[g];
            sync_q <= meta_q;
         end
      end

      assign sync_o[g] = sync_q;
   end
endmodule
`default_nettype wire

// ==== hw/rtci_timeout.sv ====
// Transaction length watchdog
`default_nettype none
module rtci_timeout #(
   parameter int CYCLES = 95000000
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic run_i,
   output logic      expire_o
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
      end else if (!run_i || cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   // Fires in the CYCLES-th cycle of an open transaction
   assign expire_o = run_i && (cnt_q == LAST); // [RL7]
endmodule
`default_nettype wire

// ==== verif/rtci_host_model.sv ====
// Bus controller model driving the two-wire target from the host side
`default_nettype none
module rtci_host_model (
   output logic      scl_oe_o,
   output logic      sda_oe_o,
   input  wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // Line control, quarter of a 125 ns bit
   // ------------------------------------------------------------------
   localparam realtime Q = 31.25;

   // Both lines released between frames, pull-ups give high
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end

   // Start or repeated start: data falls while clock is high
   task automatic start();
      sda_oe_o <= 1'b0;
      #(2*Q) scl_oe_o <= 1'b0;
      #Q sda_oe_o <= 1'b1;
      #Q scl_oe_o <= 1'b1;
      #Q;
   endtask

   // Stop: data rises while clock is high, frames other than the bus_timeout one stay short of the timeout
   task automatic stop();
      sda_oe_o <= 1'b1;
      #(2*Q) scl_oe_o <= 1'b0;
      #Q sda_oe_o <= 1'b0;
      #Q;
   endtask

   // One clock period; only pulls low or releases
   task automatic put_bit(input logic b, output logic s);
      #Q sda_oe_o <= ~b;
      #Q scl_oe_o <= 1'b0;
      #Q s = sda_i;
      #Q scl_oe_o <= 1'b1;
   endtask

   // Byte out MSB first, then target's acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], s);
      end
      put_bit(1'b1, s);
      ack = ~s;
   endtask

   // Byte in, then acknowledge or not-acknowledge from the host
   task automatic recv(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, s);
         b[i] = s;
      end
      put_bit(nack, s);
   endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the two-wire register access target
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   localparam logic [6:0] ADDR = 7'h32;
   logic       clk;
   logic       rst_b;
   logic       scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
   wire logic  scl_w;
   wire logic  sda_w;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       reg_we, reg_re, busy;
   logic [7:0] mem [256];
   int         failures = 0;
   int         compares = 0;
   int         reads    = 0;
   int         writes   = 0;

   // Open-drain wires with pull-ups
   assign scl_w = ~(m_scl | (scl_oe & ~scl_o));
   assign sda_w = ~(m_sda | (sda_oe & ~sda_o));
   assign reg_rdata = mem[reg_addr];

   rtci_slave #(.DEV_ADDR(ADDR), .TIMEOUT_CYC(2000)) DUT (
      .clk_i(clk), .rst_b_i(rst_b), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .reg_we_o(reg_we), .reg_re_o(reg_re),
      .reg_rdata_i(reg_rdata), .busy_o(busy)
   );

   rtci_host_model mst (.scl_oe_o(m_scl), .sda_oe_o(m_sda), .sda_i(sda_w));

   // ------------------------------------------------------------------
   // Clock, register file, watchdog
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'ha5;
      end
   end

   always @(posedge clk) begin
      if (reg_we === 1'b1) begin
         mem[reg_addr] <= reg_wdata;
         writes++;
      end
      if (reg_re === 1'b1) begin
         reads++;
      end
   end

   initial begin
      #500000;
      failures++;
      close_out();
   end

   task automatic close_out();
      if (failures == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic write_wrap();
      logic [4:0] ak;
      int         w0;
      w0 = writes;
      mst.start();
      mst.send({ADDR, 1'b0}, ak[4]);
      mst.send(8'h1e, ak[3]);
      mst.send(8'h11, ak[2]);
      mst.send(8'h22, ak[1]);
      mst.send(8'h33, ak[0]);
      mst.stop();
      `CHK(ak, 5'h1f)
      `CHK(mem[8'h1e], 8'h11)
      `CHK(mem[8'h1f], 8'h22)
      `CHK(mem[8'h10], 8'h33)
      `CHK(mem[8'h20], 8'h85)
      `CHK(writes - w0, 3)
   endtask

   task automatic read_addressed();
      logic [2:0] ak;
      logic [7:0] d0, d1, d2;
      int         r0;
      r0 = reads;
      mst.start();
      mst.send({ADDR, 1'b0}, ak[2]);
      mst.send(8'h1f, ak[1]);
      mst.start();
      @(negedge clk);
      `CHK(busy, 1'b1)
      mst.send({ADDR, 1'b1}, ak[0]);
      mst.recv(1'b0, d0);
      mst.recv(1'b0, d1);
      mst.recv(1'b1, d2);
      mst.stop();
      `CHK(ak, 3'h7)
      `CHK(d0, 8'h22)
      `CHK(d1, 8'h33)
      `CHK(d2, 8'hb4)
      `CHK(reads - r0, 3)
   endtask

   task automatic read_no_addr();
      logic       ak;
      logic [7:0] d;
      int         r0;
      r0 = reads;
      mst.start();
      mst.send({ADDR, 1'b1}, ak);
      mst.recv(1'b1, d);
      mst.stop();
      `CHK(ak, 1'b1)
      `CHK(d, 8'hb7)
      `CHK(reads - r0, 1)
   endtask

   task automatic wrong_addr();
      logic [1:0] ak;
      int         w0;
      w0 = writes;
      mst.start();
      mst.send({ADDR ^ 7'h01, 1'b0}, ak[1]);
      mst.send(8'h05, ak[0]);
      mst.stop();
      repeat (5) @(negedge clk);
      `CHK(ak, 2'b00)
      `CHK(mem[8'h05], 8'ha0)
      `CHK({scl_w, sda_w}, 2'b11)
      `CHK(busy, 1'b0)
      `CHK(writes - w0, 0)
   endtask

   task automatic bus_timeout();
      logic ak;
      mst.start();
      repeat (1900) @(negedge clk);
      `CHK(busy, 1'b1)
      repeat (150) @(negedge clk);
      `CHK(busy, 1'b0)
      `CHK(sda_oe, 1'b0)
      mst.stop();
      mst.start();
      mst.send({ADDR, 1'b0}, ak);
      mst.stop();
      `CHK(ak, 1'b1)
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      write_wrap();
      read_addressed();
      read_no_addr();
      wrong_addr();
      bus_timeout();
      close_out();
   end
endmodule
`default_nettype wire
